// ==== include/igf_pkg.sv ====
/*
  constants, field layouts and carrier types of the input glitch filter.
  assumes a single 200 mhz bus clock and a 12-bit axi4-lite byte address.
*/
package igf_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH       = 80;
  localparam int NUM_TICK     = 8;
  localparam int CASCADE_BASE = 3;
  localparam int CNT_W        = 5;
  localparam int RELOAD_W     = 10;
  localparam int NUM_IRQ      = 16;
  localparam int NUM_DMA      = 4;
  localparam int SYNC_STAGES  = 2;
  localparam int ADDR_W       = 12;
  localparam int DATA_W       = 32;

  // ----------------------------------------------------------------
  // counter landmarks
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_MIN      = 5'h00;
  localparam logic [CNT_W-1:0] CNT_MID_LOW  = 5'h0f;
  localparam logic [CNT_W-1:0] CNT_MID_HIGH = 5'h10;
  localparam logic [CNT_W-1:0] CNT_MAX      = 5'h1f;
  localparam logic [CNT_W-1:0] CNT_RESET    = 5'h00;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CHAN_CFG_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_BASE   = 12'h140;
  localparam logic [ADDR_W-1:0] POLSEL_OFF    = 12'h150;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFF  = 12'h154;
  localparam logic [ADDR_W-1:0] RELOAD_BASE   = 12'h160;
  localparam int                NUM_STATUS_W  = 3;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_SEL_LSB  = 0;
  localparam int CFG_MODE_LSB = 4;

  typedef enum logic [1:0] {
    IGF_MODE_RSVD   = 2'h0,
    IGF_MODE_DIRECT = 2'h1,
    IGF_MODE_SYNC   = 2'h2,
    IGF_MODE_FILTER = 2'h3
  } igf_mode_t;

  typedef struct packed {
    igf_mode_t  mode;
    logic [2:0] tick_sel;
  } igf_chan_cfg_t;

  localparam igf_chan_cfg_t    CFG_RESET    = '{mode: IGF_MODE_SYNC, tick_sel: 3'h0};
  localparam logic [RELOAD_W-1:0] RELOAD_RESET = 10'h000;
  localparam logic [NUM_IRQ-1:0]  POLSEL_RESET = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== verilog/igf_channel.sv ====
/*
  one filter channel: raw pass, two-stage synchroniser, saturating counter.
  assumes tick_i pulses are one clock wide and on the same clock.
*/
`timescale 1ns/1ps
module igf_channel (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   arst_n_i,
  // pin and setup
  input  wire logic                   pin_i,
  input  wire igf_pkg::igf_chan_cfg_t cfg_i,
  input  wire logic [7:0]             tick_i,
  // result
  output logic                        out_o
);

  // ----------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------
  logic [igf_pkg::SYNC_STAGES-1:0] sync_ff;
  logic                            synced_channel_input;
  logic [igf_pkg::CNT_W-1:0]       cnt_ff;
  logic [igf_pkg::CNT_W-1:0]       nxt_cnt;
  logic                            step;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= {sync_ff[igf_pkg::SYNC_STAGES-2:0], pin_i};
    end
  end

  assign synced_channel_input = sync_ff[igf_pkg::SYNC_STAGES-1];

  // ----------------------------------------------------------------
  // counter_filter_stage
  // ----------------------------------------------------------------
  // counter holds its value outside filter mode, so a later mode change resumes from the old count
  assign step = (cfg_i.mode == igf_pkg::IGF_MODE_FILTER) && tick_i[cfg_i.tick_sel];

  always_comb begin
    nxt_cnt = cnt_ff;
    if (step) begin
      if (synced_channel_input) begin
        if (cnt_ff == igf_pkg::CNT_MID_LOW) begin
          nxt_cnt = igf_pkg::CNT_MAX;
        end else if (cnt_ff != igf_pkg::CNT_MAX) begin
          nxt_cnt = cnt_ff + 5'h01;
        end
      end else begin
        if (cnt_ff == igf_pkg::CNT_MID_HIGH) begin
          nxt_cnt = igf_pkg::CNT_MIN;
        end else if (cnt_ff != igf_pkg::CNT_MIN) begin
          nxt_cnt = cnt_ff - 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= igf_pkg::CNT_RESET;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // output select
  // ----------------------------------------------------------------
  always_comb begin
    unique case (cfg_i.mode)
      igf_pkg::IGF_MODE_DIRECT: out_o = pin_i;
      igf_pkg::IGF_MODE_FILTER: out_o = cnt_ff[igf_pkg::CNT_W-1];
      igf_pkg::IGF_MODE_SYNC:   out_o = synced_channel_input;
      default:                  out_o = synced_channel_input;
    endcase
  end

endmodule // igf_channel

// ==== verilog/igf_top.sv ====
/*
  input glitch filter top: 80 channels, central divider, axi4-lite registers.
  assumes pins are asynchronous and software sets dividers and modes once.
*/
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module igf_top (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        arst_n_i,
  // axi4-lite write address
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [igf_pkg::ADDR_W-1:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [igf_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  // axi4-lite write response
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output logic [1:0]                       s_axi_bresp,
  // axi4-lite read address
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [igf_pkg::ADDR_W-1:0]  s_axi_araddr,
  // axi4-lite read data
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [igf_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  // pins in, filtered out
  input  wire logic [igf_pkg::NUM_CH-1:0]  filt_in_i,
  output logic [igf_pkg::NUM_CH-1:0]       filt_out_o,
  // interrupt and dma consumers
  output logic [igf_pkg::NUM_IRQ-1:0]      irq_o,
  output logic [igf_pkg::NUM_DMA-1:0]      dma_req_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  igf_pkg::igf_chan_cfg_t              chan_cfg_ff  [igf_pkg::NUM_CH];
  logic [igf_pkg::RELOAD_W-1:0]        divider_stage_reload [igf_pkg::NUM_TICK];
  logic [igf_pkg::RELOAD_W-1:0]        div_cnt_ff   [igf_pkg::NUM_TICK];
  logic [igf_pkg::NUM_TICK-1:0]        tick_ff;
  logic [igf_pkg::NUM_TICK-1:0]        stage_en;
  logic [igf_pkg::NUM_IRQ-1:0]         interrupt_polarity_select;
  logic [igf_pkg::NUM_CH-1:0]          chan_out;

  // write channel state
  logic                                aw_full_ff;
  logic                                w_full_ff;
  logic [igf_pkg::ADDR_W-1:0]          awaddr_ff;
  logic [igf_pkg::DATA_W-1:0]          wdata_ff;
  logic [3:0]                          wstrb_ff;
  logic                                bvalid_ff;
  logic [1:0]                          bresp_ff;

  // read channel state
  logic                                rvalid_ff;
  logic [igf_pkg::DATA_W-1:0]          rdata_ff;
  logic [1:0]                          rresp_ff;

  // ----------------------------------------------------------------
  // central divider
  // ----------------------------------------------------------------
  // stages up to the cascade base run on every clock; later ones on its tick
  genvar gs;
  generate
    for (gs = 0; gs < igf_pkg::NUM_TICK; gs++) begin : g_stage
      if (gs > igf_pkg::CASCADE_BASE) begin : g_casc
        assign stage_en[gs] = tick_ff[igf_pkg::CASCADE_BASE];
      end else begin : g_base
        assign stage_en[gs] = 1'b1;
      end

      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          div_cnt_ff[gs] <= igf_pkg::RELOAD_RESET;
          tick_ff[gs]    <= 1'b0;
        end else begin
          tick_ff[gs] <= stage_en[gs] && (div_cnt_ff[gs] == '0);
          if (stage_en[gs]) begin
            if (div_cnt_ff[gs] == '0) begin
              div_cnt_ff[gs] <= divider_stage_reload[gs];
            end else begin
              div_cnt_ff[gs] <= div_cnt_ff[gs] - 10'h001;
            end
          end
        end
      end
    end
  endgenerate

  // named copies of the first and last tick for waveform viewing
  logic divided_tick_0;
  logic divided_tick_7;
  assign divided_tick_0 = tick_ff[0];
  assign divided_tick_7 = tick_ff[igf_pkg::NUM_TICK-1];

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  genvar gc;
  generate
    for (gc = 0; gc < igf_pkg::NUM_CH; gc++) begin : g_chan
      igf_channel u_chan (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .pin_i    (filt_in_i[gc]),
        .cfg_i    (chan_cfg_ff[gc]),
        .tick_i   (tick_ff),
        .out_o    (chan_out[gc])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // consumer outputs
  // ----------------------------------------------------------------
  // sync latency of two clocks is inherent to the channel, no extra stage
  assign filt_out_o = chan_out;
  assign irq_o      = chan_out[igf_pkg::NUM_IRQ-1:0] ^ interrupt_polarity_select;
  // dma side trusts software to keep these channels in sync mode
  assign dma_req_o  = chan_out[igf_pkg::NUM_DMA-1:0] ^
                      interrupt_polarity_select[igf_pkg::NUM_DMA-1:0];

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  localparam logic [igf_pkg::ADDR_W-1:0] CHAN_END   = igf_pkg::CHAN_CFG_BASE + 12'(igf_pkg::NUM_CH * 4);
  localparam logic [igf_pkg::ADDR_W-1:0] STATUS_END = igf_pkg::STATUS_BASE + 12'(igf_pkg::NUM_STATUS_W * 4);
  localparam logic [igf_pkg::ADDR_W-1:0] RELOAD_END = igf_pkg::RELOAD_BASE + 12'(igf_pkg::NUM_TICK * 4);

  logic                                do_write;
  logic [igf_pkg::ADDR_W-1:0]          w_off;
  logic [6:0]                          w_ch_idx;
  logic [2:0]                          w_rl_idx;
  logic                                w_cfg_hit;
  logic                                w_status_hit;
  logic                                w_pol_hit;
  logic                                w_istat_hit;
  logic                                w_rl_hit;
  logic                                w_mapped;

  assign do_write     = aw_full_ff && w_full_ff && !bvalid_ff;
  assign w_off        = {awaddr_ff[igf_pkg::ADDR_W-1:2], 2'b00};
  assign w_ch_idx     = 7'((w_off - igf_pkg::CHAN_CFG_BASE) >> 2);
  assign w_rl_idx     = 3'((w_off - igf_pkg::RELOAD_BASE) >> 2);
  assign w_cfg_hit    = (w_off >= igf_pkg::CHAN_CFG_BASE) && (w_off < CHAN_END);
  assign w_status_hit = (w_off >= igf_pkg::STATUS_BASE) && (w_off < STATUS_END);
  assign w_pol_hit    = (w_off == igf_pkg::POLSEL_OFF);
  assign w_istat_hit  = (w_off == igf_pkg::IRQ_STAT_OFF);
  assign w_rl_hit     = (w_off >= igf_pkg::RELOAD_BASE) && (w_off < RELOAD_END);
  assign w_mapped     = w_cfg_hit || w_status_hit || w_pol_hit || w_istat_hit || w_rl_hit;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_full_ff && !bvalid_ff;
  assign s_axi_wready  = !w_full_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_full_ff <= 1'b0;
      awaddr_ff  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w_full_ff <= 1'b0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end else if (do_write) begin
      w_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= igf_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= w_mapped ? igf_pkg::RESP_OKAY : igf_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // no lock against live changes: glitches on a retune are software's risk
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < igf_pkg::NUM_CH; i++) begin
        chan_cfg_ff[i] <= igf_pkg::CFG_RESET;
      end
    end else if (do_write && w_cfg_hit && wstrb_ff[0]) begin
      chan_cfg_ff[w_ch_idx] <= '{mode: igf_pkg::igf_mode_t'(wdata_ff[igf_pkg::CFG_MODE_LSB +: 2]),
                                 tick_sel: wdata_ff[igf_pkg::CFG_SEL_LSB +: 3]};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < igf_pkg::NUM_TICK; i++) begin
        divider_stage_reload[i] <= igf_pkg::RELOAD_RESET;
      end
    end else if (do_write && w_rl_hit) begin
      if (wstrb_ff[0]) begin
        divider_stage_reload[w_rl_idx][7:0] <= wdata_ff[7:0];
      end
      if (wstrb_ff[1]) begin
        divider_stage_reload[w_rl_idx][igf_pkg::RELOAD_W-1:8] <= wdata_ff[igf_pkg::RELOAD_W-1:8];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      interrupt_polarity_select <= igf_pkg::POLSEL_RESET;
    end else if (do_write && w_pol_hit) begin
      if (wstrb_ff[0]) begin
        interrupt_polarity_select[7:0] <= wdata_ff[7:0];
      end
      if (wstrb_ff[1]) begin
        interrupt_polarity_select[15:8] <= wdata_ff[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  logic [igf_pkg::ADDR_W-1:0]          r_off;
  logic [6:0]                          r_ch_idx;
  logic [2:0]                          r_rl_idx;
  logic [1:0]                          r_st_idx;
  logic                                r_cfg_hit;
  logic                                r_status_hit;
  logic                                r_pol_hit;
  logic                                r_istat_hit;
  logic                                r_rl_hit;
  logic [95:0]                         status_vec;
  logic [igf_pkg::DATA_W-1:0]          cfg_word;
  logic [igf_pkg::DATA_W-1:0]          rd_word;

  assign r_off        = {s_axi_araddr[igf_pkg::ADDR_W-1:2], 2'b00};
  assign r_ch_idx     = 7'((r_off - igf_pkg::CHAN_CFG_BASE) >> 2);
  assign r_rl_idx     = 3'((r_off - igf_pkg::RELOAD_BASE) >> 2);
  assign r_st_idx     = 2'((r_off - igf_pkg::STATUS_BASE) >> 2);
  assign r_cfg_hit    = (r_off >= igf_pkg::CHAN_CFG_BASE) && (r_off < CHAN_END);
  assign r_status_hit = (r_off >= igf_pkg::STATUS_BASE) && (r_off < STATUS_END);
  assign r_pol_hit    = (r_off == igf_pkg::POLSEL_OFF);
  assign r_istat_hit  = (r_off == igf_pkg::IRQ_STAT_OFF);
  assign r_rl_hit     = (r_off >= igf_pkg::RELOAD_BASE) && (r_off < RELOAD_END);
  assign status_vec   = {16'h0000, chan_out};
  assign cfg_word     = {26'h0000000, chan_cfg_ff[r_ch_idx].mode, 1'b0, chan_cfg_ff[r_ch_idx].tick_sel};

  assign rd_word = r_cfg_hit    ? cfg_word :
                   r_status_hit ? status_vec[r_st_idx*32 +: 32] :
                   r_pol_hit    ? {16'h0000, interrupt_polarity_select} :
                   r_istat_hit  ? {16'h0000, irq_o} :
                   r_rl_hit     ? {22'h000000, divider_stage_reload[r_rl_idx]} :
                                  32'h0000_0000;

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= igf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= (r_cfg_hit || r_status_hit || r_pol_hit || r_istat_hit || r_rl_hit) ?
                   igf_pkg::RESP_OKAY : igf_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule // igf_top

// ==== tb/igf_top_checker.sv ====
/* port assertions for igf_top.
   assumes channel 79 is left in sync mode by the bench. */
`timescale 1ns/1ps
module igf_top_checker (
  // clock and reset
  input wire logic                       clk_i,
  input wire logic                       arst_n_i,
  // register bus
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  // pins and consumers
  input wire logic [igf_pkg::NUM_CH-1:0] filt_in_i,
  input wire logic [igf_pkg::NUM_CH-1:0] filt_out_o,
  input wire logic [15:0]                irq_o,
  input wire logic [3:0]                 dma_req_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  chk_read_answer: assert property (rd_taken |-> ##[1:2] s_axi_rvalid) else $error("read not answered");
  chk_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid repeated");
  chk_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid repeated");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
  chk_reset_quiet: assert property ($rose(arst_n_i) |-> filt_out_o == '0 && irq_o == '0)
    else $error("outputs not low after reset");
  chk_sync_path: assert property (filt_out_o[79] == $past(filt_in_i[79], 2))
    else $error("sync channel not two clocks");
  chk_irq_dma: assert property (irq_o[3:0] == dma_req_o)
    else $error("irq and dma disagree");
endmodule // igf_top_checker

bind igf_top igf_top_checker igf_top_checker_i (.clk_i, .arst_n_i, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .filt_in_i, .filt_out_o, .irq_o, .dma_req_o);

// ==== tb/igf_pin_model.sv ====
/* external pin model for the filter inputs.
   assumes the bench sets the wanted levels. */
`timescale 1ns/1ps
module igf_pin_model (
  // wanted levels
  input  wire logic [igf_pkg::NUM_CH-1:0] level_i,
  // pins toward the filter
  output wire logic [igf_pkg::NUM_CH-1:0] pin_o
);
  // off-grid edges, since real pins ignore the clock
  assign #1.3 pin_o = level_i;
endmodule // igf_pin_model

// ==== tb/igf_top_tb_top.sv ====
/* self-checking bench for igf_top over axi4-lite.
   assumes the bound checker and igf_pin_model on the pins. */
`timescale 1ns/1ps
module igf_top_tb_top;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [79:0] lvl = '0, filt_in_i, filt_out_o;
  logic [15:0] irq_o;
  logic [3:0]  dma_req_o;
  int          error_cnt = 0, comparisons = 0;
  always #2.5 clk_i = ~clk_i;
  igf_pin_model igf_pin_model_i (.level_i(lvl), .pin_o(filt_in_i));
  igf_top igf_top_i (.clk_i, .arst_n_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .filt_in_i, .filt_out_o, .irq_o, .dma_req_o);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic timeout;
    error_cnt++;
    $display("MISMATCH t=%0t bus gave no answer", $time);
    results();
  endtask
  // settle after n edges, sampling mid-cycle
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) timeout();
    check(32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) timeout();
    check(s_axi_rdata, exp);
    check(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(12'h000, 32'h20, 2'h0);
    rd(12'h160, 32'h0, 2'h0);
    rd(12'h150, 32'h0, 2'h0);
    rd(12'h200, 32'h0, 2'h2);
    wr(12'h200, 32'hffff, 2'h2);
    wr(12'h150, 32'h6, 2'h0);
    w(0);
    check(32'(irq_o), 32'h6);
    rd(12'h154, 32'h6, 2'h0);
    @(posedge clk_i) lvl[2] <= 1'b1;
    w(3);
    check(32'(dma_req_o), 32'h2);
    wr(12'h150, 32'h0, 2'h0);
    // all setup done while only pin 2 is high
    wr(12'h008, 32'h20, 2'h0);
    wr(12'h010, 32'h10, 2'h0);
    wr(12'h020, 32'h30, 2'h0);
    wr(12'h024, 32'h34, 2'h0);
    wr(12'h160, 32'h1, 2'h0);
    wr(12'h16c, 32'h1, 2'h0);
    wr(12'h170, 32'h1, 2'h0);
    rd(12'h024, 32'h34, 2'h0);
    @(posedge clk_i) lvl[79] <= 1'b1;
    lvl[6] <= 1'b1;
    lvl[4] <= 1'b1;
    w(0);
    check(32'(filt_out_o[4]), 32'h1);
    w(1);
    check(32'(filt_out_o[6]), 32'h0);
    w(1);
    check(32'(filt_out_o[6]), 32'h1);
    @(posedge clk_i) lvl[4] <= 1'b0;
    w(0);
    check(32'(filt_out_o[4]), 32'h0);
    rd(12'h140, 32'h44, 2'h0);
    rd(12'h148, 32'h8000, 2'h0);
    // ch8 steps every 2 clocks, ch9 every 4 through the cascade
    @(posedge clk_i) lvl[9:8] <= 2'h3;
    w(20);
    check(32'(filt_out_o[9:8]), 32'h0);
    w(25);
    check(32'(filt_out_o[9:8]), 32'h1);
    w(35);
    check(32'(filt_out_o[9:8]), 32'h3);
    @(posedge clk_i) lvl[8] <= 1'b0;
    w(6);
    @(posedge clk_i) lvl[8] <= 1'b1;
    w(10);
    check(32'(filt_out_o[8]), 32'h1);
    @(posedge clk_i) lvl[8] <= 1'b0;
    w(20);
    check(32'(filt_out_o[8]), 32'h1);
    w(25);
    check(32'(filt_out_o[8]), 32'h0);
    // a restart from zero would still be low here
    @(posedge clk_i) lvl[8] <= 1'b1;
    w(20);
    @(posedge clk_i) lvl[8] <= 1'b0;
    w(6);
    @(posedge clk_i) lvl[8] <= 1'b1;
    w(29);
    check(32'(filt_out_o[8]), 32'h1);
    // mode code 0 acts as sync; a byte-0 strobe keeps reload bits 9:8
    wr(12'h018, 32'h0, 2'h0);
    rd(12'h018, 32'h0, 2'h0);
    w(0);
    check(32'(filt_out_o[6]), 32'h1);
    @(posedge clk_i) s_axi_wstrb <= 4'h1;
    wr(12'h17c, 32'h3ff, 2'h0);
    @(posedge clk_i) s_axi_wstrb <= 4'hf;
    rd(12'h17c, 32'hff, 2'h0);
    results();
  end
endmodule // igf_top_tb_top
